/* hw/iei_event_irq.sv */
// Invalidation-event interrupt generator with its Wishbone registers.
// Assumes the queue logic gives a one-cycle completion pulse on mclk.
//
// Implementation choice: register access over Wishbone.

// Operation
// - Event mask resets to one.
// - Unmasked condition sends message from registers.
// - Never send while mask is set.
// - Condition sets the pending bit.
// - Condition is flagged wait completion.
// - Already set status means no new condition.
// - Pending holds while message held back.
// - Issuing the held message clears pending.
// - Software servicing status clears pending silently.
// - Upper data meaningful with 32-bit support.
// - Without it upper data reads zero.
// - Low data field is message data.
// - Address bits 31:2, low bits zero.
// - Without queue support registers read zero; irq status and mask still read back.
// - Status bit 0 set by hardware, W1C.
// - Upper address register supplies high address.
module iei_event_irq
#(
    parameter bit          QI_SUPPORT     = 1'b1, // Queue support present
    parameter bit          DATA32_SUPPORT = 1'b1, // 32-bit message data
    parameter bit          EXT_INT_SUPPORT = 1'b1, // Upper address used
    parameter int          ADDR_W         = 12    // Bus byte address width
)
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              waitDone,
    input  wire logic              waitIrqFlag,
    input  wire logic              msgReady,
    output logic                   msgValid,
    output iei_pkg::iei_msg_s      msgWrite,
    output logic                   irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic                        eventMask;       // Holds messages back
    logic                        eventPending;    // Message owed
    logic                        waitDoneStatus;  // Completion status
    logic [15:0]                 lowMsgData;      // Message data low
    logic [15:0]                 upperMsgData;    // Message data high
    logic [29:0]                 msgDwordAddress; // Dword address
    logic [31:0]                 upperAddress;    // High address word
    logic [iei_pkg::IRQ_W-1:0]   irqStatus;       // Sticky events
    logic [iei_pkg::IRQ_W-1:0]   irqMask;         // Event enables
    logic                        busReq;          // New bus cycle
    logic                        busWr;           // Write this edge
    logic [11:0]                 regAddr;         // Word-aligned offset
    logic [31:0]                 readValue;       // Read mux result
    logic                        newCond;         // Fresh condition
    logic                        swService;       // W1C on set status
    logic                        msgSent;         // Handshake done
    logic                        sendReq;         // Ask sender to go
    logic [iei_pkg::IRQ_W-1:0]   irqEvents;       // Event pulses
    iei_pkg::iei_msg_s           msgSrc;          // Live message image
    logic [31:0]                 addrWord;        // Address after byte merge

    // Merge write data into a word under byte enables
    function automatic logic [31:0] merge_bytes
    (
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[8*b +: 8] = wdat[8*b +: 8];
        end
        return res;
    endfunction : merge_bytes

    // Write strobe toward one register offset
    function automatic logic hit
    (
        input logic       wr,
        input logic [11:0] addr,
        input logic [11:0] off
    );
        return wr && (addr == off);
    endfunction : hit

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    assign regAddr = 12'({wb_adr_i[ADDR_W-1:2], 2'b00});
    assign busReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWr   = busReq && wb_we_i;

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge mclk)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= busReq;
    end

    // Read data captured with the ack; unmapped reads return zero
    always_ff @(posedge mclk)
    begin
        if (rst)
            wb_dat_o <= iei_pkg::RST_WORD;
        else if (busReq && !wb_we_i)
            wb_dat_o <= readValue;
    end

    // Read mux; queue-less builds hide all but the irq status and mask
    always_comb
    begin
        readValue = iei_pkg::RST_WORD;
        case (regAddr)
            iei_pkg::OFF_COMP_STATUS:
                readValue[iei_pkg::WAIT_DONE_BIT] = waitDoneStatus;
            iei_pkg::OFF_EVT_CTRL:
            begin
                // Reserved low bits read zero
                readValue[iei_pkg::MASK_BIT] = eventMask;
                readValue[iei_pkg::PEND_BIT] = eventPending;
            end
            iei_pkg::OFF_MSG_DATA:
                readValue = {upperMsgData, lowMsgData};
            iei_pkg::OFF_MSG_ADDR:
                readValue = {msgDwordAddress, 2'b00};
            iei_pkg::OFF_UPPER_ADDR:
                readValue = upperAddress;
            iei_pkg::OFF_IRQ_STATUS:
                readValue[iei_pkg::IRQ_W-1:0] = irqStatus;
            iei_pkg::OFF_IRQ_MASK:
                readValue[iei_pkg::IRQ_W-1:0] = irqMask;
            default:
                readValue = iei_pkg::RST_WORD;
        endcase
        // Own irq registers stay visible either way
        if (!QI_SUPPORT && regAddr != iei_pkg::OFF_IRQ_STATUS &&
            regAddr != iei_pkg::OFF_IRQ_MASK)
            readValue = iei_pkg::RST_WORD;
    end

    // ****************************************************************
    // Completion status and condition detect
    // ****************************************************************
    // Only a flagged completion on a clear status is a new condition
    assign newCond = QI_SUPPORT && waitDone && waitIrqFlag &&
                     !waitDoneStatus;

    // Software writes one to bit 0 while it is set
    assign swService = hit(busWr, regAddr, iei_pkg::OFF_COMP_STATUS) &&
                       wb_sel_i[0] && wb_dat_i[iei_pkg::WAIT_DONE_BIT] &&
                       waitDoneStatus;

    // Hardware set wins over a same-cycle clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            waitDoneStatus <= 1'b0;
        else if (QI_SUPPORT && waitDone && waitIrqFlag)
            waitDoneStatus <= 1'b1;
        else if (swService)
            waitDoneStatus <= 1'b0;
    end

    // ****************************************************************
    // Event control
    // ****************************************************************
    // Mask comes out of reset set so nothing fires unprogrammed
    always_ff @(posedge mclk)
    begin
        if (rst)
            eventMask <= iei_pkg::RST_MASK;
        else if (QI_SUPPORT && wb_sel_i[3] &&
                 hit(busWr, regAddr, iei_pkg::OFF_EVT_CTRL))
            eventMask <= wb_dat_i[iei_pkg::MASK_BIT];
    end

    // Pending: set wins, then sent or serviced clears, else holds
    always_ff @(posedge mclk)
    begin
        if (rst)
            eventPending <= iei_pkg::RST_PEND;
        else if (newCond)
            eventPending <= 1'b1;
        else if (msgSent)
            eventPending <= 1'b0;
        else if (swService)
            eventPending <= 1'b0;
        // Otherwise held through mask or a stalled fabric
    end

    // ****************************************************************
    // Message registers
    // ****************************************************************
    // Data: upper half only kept with 32-bit support
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lowMsgData   <= '0;
            upperMsgData <= '0;
        end
        else if (QI_SUPPORT && hit(busWr, regAddr, iei_pkg::OFF_MSG_DATA))
        begin
            {upperMsgData, lowMsgData} <= merge_bytes(
                {upperMsgData, lowMsgData}, wb_dat_i, wb_sel_i);
            if (!DATA32_SUPPORT)
                upperMsgData <= '0;
        end
    end

    // Whole word merged first; a call result cannot be sliced directly
    assign addrWord = merge_bytes({msgDwordAddress, 2'b00}, wb_dat_i,
                                  wb_sel_i);

    // Address: bits 1:0 are not stored, so they always read zero
    always_ff @(posedge mclk)
    begin
        if (rst)
            msgDwordAddress <= '0;
        else if (QI_SUPPORT && hit(busWr, regAddr, iei_pkg::OFF_MSG_ADDR))
            msgDwordAddress <= addrWord[31:iei_pkg::ADDR_LSB];
    end

    // Upper address only exists with queues and extended mode
    always_ff @(posedge mclk)
    begin
        if (rst)
            upperAddress <= iei_pkg::RST_WORD;
        else if (QI_SUPPORT && EXT_INT_SUPPORT &&
                 hit(busWr, regAddr, iei_pkg::OFF_UPPER_ADDR))
            upperAddress <= merge_bytes(upperAddress, wb_dat_i,
                wb_sel_i);
    end

    // ****************************************************************
    // Message issue
    // ****************************************************************
    // Live image; the sender freezes it before offering
    always_comb
    begin
        msgSrc           = '0;
        msgSrc.upperAddr = upperAddress;
        msgSrc.dwordAddr = msgDwordAddress;
        msgSrc.data      = {upperMsgData, lowMsgData};
    end

    // Mask withholds the request entirely
    assign sendReq = eventPending && !eventMask;

    iei_msg_sender iei_msg_sender_i
    (
        .mclk     (mclk),
        .rst      (rst),
        .sendReq  (sendReq),
        .msgReady (msgReady),
        .msgSrc   (msgSrc),
        .msgWrite (msgWrite),
        .msgValid (msgValid),
        .msgSent  (msgSent)
    );

    // ****************************************************************
    // Local interrupt
    // ****************************************************************
    always_comb
    begin
        irqEvents                        = '0;
        irqEvents[iei_pkg::IRQ_SEEN]     = newCond;
        irqEvents[iei_pkg::IRQ_SENT]     = msgSent;
        irqEvents[iei_pkg::IRQ_SERVICED] = swService && eventPending &&
                                           !msgSent && !newCond;
    end

    // Sticky status, write one clears, new events win
    always_ff @(posedge mclk)
    begin
        if (rst)
            irqStatus <= iei_pkg::RST_IRQ;
        else if (wb_sel_i[0] &&
                 hit(busWr, regAddr, iei_pkg::OFF_IRQ_STATUS))
            irqStatus <= (irqStatus & ~wb_dat_i[iei_pkg::IRQ_W-1:0]) |
                         irqEvents;
        else
            irqStatus <= irqStatus | irqEvents;
    end

    // Enables, all off after reset
    always_ff @(posedge mclk)
    begin
        if (rst)
            irqMask <= iei_pkg::RST_IRQ;
        else if (wb_sel_i[0] && hit(busWr, regAddr, iei_pkg::OFF_IRQ_MASK))
            irqMask <= wb_dat_i[iei_pkg::IRQ_W-1:0];
    end

    assign irq = |(irqStatus & irqMask);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    mask_reset_a: assert property (@(posedge mclk)
        $past(rst) && !rst |-> eventMask)
        else $error("event mask not set after reset");

    unmasked_send_a: assert property (@(posedge mclk)
        disable iff (rst)
        eventPending && !eventMask |-> ##[0:3]
        (msgValid || !eventPending || eventMask))
        else $error("unmasked pending message not offered");

    masked_silent_a: assert property (@(posedge mclk)
        disable iff (rst)
        eventMask |-> !msgValid && !msgSent)
        else $error("message offered while masked");

    // Queue-less builds never see a condition
    cond_pending_a: assert property (@(posedge mclk)
        disable iff (rst)
        QI_SUPPORT && waitDone && waitIrqFlag && !waitDoneStatus |=>
        eventPending && waitDoneStatus)
        else $error("condition did not set pending");

    repeat_cond_a: assert property (@(posedge mclk)
        disable iff (rst)
        waitDone && waitIrqFlag && waitDoneStatus && !eventPending |=>
        !eventPending)
        else $error("repeat completion raised pending");

    pending_hold_a: assert property (@(posedge mclk)
        disable iff (rst)
        eventPending && !msgSent && !swService |=> eventPending)
        else $error("pending dropped while held");

    sent_clears_a: assert property (@(posedge mclk)
        disable iff (rst)
        msgSent && !newCond |=> !eventPending && !msgValid)
        else $error("pending kept after message issued");

    // Same-cycle completion re-sets the status, so leave it out
    service_clears_a: assert property (@(posedge mclk)
        disable iff (rst)
        swService && !(waitDone && waitIrqFlag) |=>
        !eventPending && !waitDoneStatus)
        else $error("service did not clear pending");

    narrow_data_a: assert property (@(posedge mclk)
        disable iff (rst)
        msgValid |-> DATA32_SUPPORT || msgWrite.data[31:16] == 16'h0000)
        else $error("upper data sent without support");

    wb_ack_a: assert property (@(posedge mclk) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");

    send_cov: cover property (@(posedge mclk) disable iff (rst)
        newCond ##[1:10] msgSent);
    held_cov: cover property (@(posedge mclk) disable iff (rst)
        eventPending && eventMask ##[1:20] msgSent);
    service_cov: cover property (@(posedge mclk) disable iff (rst)
        eventPending && swService);

endmodule : iei_event_irq

/* hw/iei_pkg.sv */
// Constants and carrier types of the invalidation-event interrupt block.
// Assumes a 32-bit Wishbone register bus and one clock domain.

package iei_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFF_COMP_STATUS = 12'h09C; // Completion status
    localparam logic [11:0] OFF_EVT_CTRL    = 12'h0A0; // Event control
    localparam logic [11:0] OFF_MSG_DATA    = 12'h0A4; // Message data
    localparam logic [11:0] OFF_MSG_ADDR    = 12'h0A8; // Message address
    localparam logic [11:0] OFF_UPPER_ADDR  = 12'h0AC; // Upper address
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h0B0; // Sticky irq status
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h0B4; // Irq enable mask

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MASK_BIT      = 31; // Event mask in control
    localparam int PEND_BIT      = 30; // Event pending in control
    localparam int WAIT_DONE_BIT = 0;  // Wait-done status bit
    localparam int LOW_DATA_W    = 16; // Low message data width
    localparam int ADDR_LSB      = 2;  // Dword address starts here
    localparam int IRQ_W         = 3;  // Sticky event count
    localparam int IRQ_SEEN      = 0;  // Condition detected
    localparam int IRQ_SENT      = 1;  // Message issued
    localparam int IRQ_SERVICED  = 2;  // Pending dropped by software

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic              RST_MASK     = 1'b1;
    localparam logic              RST_PEND     = 1'b0;
    localparam logic [31:0]       RST_WORD     = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  RST_IRQ      = 3'h0;

    // Message sender states, gray along idle-load-issue
    typedef enum logic [1:0]
    {
        SND_IDLE  = 2'b00,
        SND_LOAD  = 2'b01,
        SND_ISSUE = 2'b11
    } iei_send_e;

    // One interrupt message write
    typedef struct packed
    {
        logic [31:0] upperAddr;
        logic [29:0] dwordAddr;
        logic [31:0] data;
    } iei_msg_s;

endpackage : iei_pkg

/* hw/iei_msg_sender.sv */
// Issues one interrupt message write toward the delivery fabric.
// Assumes the fabric runs on mclk and answers msgValid with msgReady.

module iei_msg_sender
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             sendReq,
    input  wire logic             msgReady,
    input  wire iei_pkg::iei_msg_s msgSrc,
    output iei_pkg::iei_msg_s     msgWrite,
    output logic                  msgValid,
    output logic                  msgSent
);

    // ****************************************************************
    // State
    // ****************************************************************
    iei_pkg::iei_send_e state; // Sender position

    // Idle, capture contents, then offer until taken or withdrawn
    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= iei_pkg::SND_IDLE;
        else
        begin
            case (state)
                iei_pkg::SND_IDLE:
                    if (sendReq)
                        state <= iei_pkg::SND_LOAD;
                iei_pkg::SND_LOAD:
                    // Withdrawn before offer: nothing goes out
                    state <= sendReq ? iei_pkg::SND_ISSUE
                                     : iei_pkg::SND_IDLE;
                iei_pkg::SND_ISSUE:
                    // Mask or service withdraws, handshake finishes
                    if (!sendReq || msgReady)
                        state <= iei_pkg::SND_IDLE;
                default:
                    state <= iei_pkg::SND_IDLE;
            endcase
        end
    end

    // Freeze contents so a register write cannot tear a message
    always_ff @(posedge mclk)
    begin
        if (rst)
            msgWrite <= '0;
        else if (state == iei_pkg::SND_LOAD)
            msgWrite <= msgSrc;
    end

    // Offer drops the moment the request goes away
    assign msgValid = (state == iei_pkg::SND_ISSUE) && sendReq;
    assign msgSent  = msgValid && msgReady;

endmodule : iei_msg_sender

/* test/iei_fabric_model.sv */
// Model of the interrupt delivery fabric that takes message writes.
// Assumes the message link runs on mclk with a level ready.

module iei_fabric_model
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              stall,
    input  wire logic              msgValid,
    input  wire iei_pkg::iei_msg_s msgWrite,
    output logic                   msgReady,
    output iei_pkg::iei_msg_s      lastMsg,
    output logic [7:0]             msgCount
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Acceptance
    // ****************************************************************
    // Ready is a level; stall lets the bench hold a message back
    assign msgReady = !stall;

    // Each accepted write is one whole dword message, counted once
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            msgCount <= 8'h00;
            lastMsg  <= '0;
        end
        else if (msgValid && msgReady)
        begin
            msgCount <= msgCount + 8'h01;
            lastMsg  <= msgWrite;
        end
    end
endmodule : iei_fabric_model

/* test/iei_event_irq_bench.sv */
// Self-checking bench of the invalidation-event interrupt block.
// Assumes the fabric model beside it and one 40 MHz clock.

module iei_event_irq_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    localparam logic [11:0] STAT = iei_pkg::OFF_COMP_STATUS;
    localparam logic [11:0] CTRL = iei_pkg::OFF_EVT_CTRL;
    localparam logic [11:0] IRQS = iei_pkg::OFF_IRQ_STATUS;
    localparam logic [11:0] IRQM = iei_pkg::OFF_IRQ_MASK;
    logic              mclk     = 1'b0;
    logic              rst      = 1'b1;
    logic              wbCyc    = 1'b0;
    logic              wbStb    = 1'b0;
    logic              wbWe     = 1'b0;
    logic [11:0]       wbAdr    = 12'h000;
    logic [31:0]       wbDat    = 32'h0000_0000;
    logic              waitDone = 1'b0;
    logic              waitFlag = 1'b0;
    logic              stall    = 1'b0;
    logic              msgReady;
    logic [31:0]       datO [3];
    logic              ackO [3];
    logic              msgValid [3];
    iei_pkg::iei_msg_s msgW [3];
    logic              irq [3];
    iei_pkg::iei_msg_s lastMsg;
    logic [7:0]        msgCount;
    logic [31:0]       rdv [3];      // Read data of each instance
    int                fails       = 0;
    int                comparisons = 0;
    int                cycles      = 0;

    // Half period of 12.5 ns gives 40 MHz
    always #12.5 mclk = ~mclk;

    // Instance 1 lacks queue support, instance 2 lacks 32-bit data
    genvar g;
    for (g = 0; g < 3; g++)
    begin : dut
        iei_event_irq #(.QI_SUPPORT(g != 1), .DATA32_SUPPORT(g != 2))
        iei_event_irq_i
        (
            .mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
            .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
            .wb_dat_i(wbDat), .wb_dat_o(datO[g]), .wb_ack_o(ackO[g]),
            .waitDone(waitDone), .waitIrqFlag(waitFlag),
            .msgReady(msgReady), .msgValid(msgValid[g]),
            .msgWrite(msgW[g]), .irq(irq[g])
        );
    end

    iei_fabric_model iei_fabric_model_i
    (
        .mclk(mclk), .rst(rst), .stall(stall), .msgValid(msgValid[0]),
        .msgWrite(msgW[0]), .msgReady(msgReady), .lastMsg(lastMsg),
        .msgCount(msgCount)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One classic cycle; held until ack is sampled, then released
    // Waits as long as it takes; only the hang guard ends a wait
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= w;
        wbAdr <= a;
        wbDat <= d;
        @(posedge mclk);
        while (ackO[0] !== 1'b1)
            @(posedge mclk);
        for (int i = 0; i < 3; i++)
            rdv[i] = datO[i];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : bus

    // Flagged wait completion, one cycle long
    task automatic pulse();
        @(posedge mclk);
        waitDone <= 1'b1;
        waitFlag <= 1'b1;
        @(posedge mclk);
        waitDone <= 1'b0;
    endtask : pulse

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the fewer than two hundred cycles needed
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h8000_0000);
        check32(rdv[1], 32'h0000_0000);
        bus(IRQM, 1'b1, 32'h0000_0007);
        bus(12'h0A4, 1'b1, 32'hABCD_1234);
        bus(12'h0A4, 1'b0, 32'h0);
        check32(rdv[0], 32'hABCD_1234);
        check32(rdv[2], 32'h0000_1234);
        check32(rdv[1], 32'h0000_0000);
        bus(12'h0A8, 1'b1, 32'h1234_567B);
        bus(12'h0A8, 1'b0, 32'h0);
        check32(rdv[0], 32'h1234_5678);
        bus(12'h0AC, 1'b1, 32'hFEDC_BA98);
        bus(12'h0AC, 1'b0, 32'h0);
        check32(rdv[0], 32'hFEDC_BA98);
        // Masked condition: pending, but nothing leaves
        pulse();
        repeat (10) @(posedge mclk);
        check32({24'h0, msgCount}, 32'h0);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'hC000_0000);
        bus(STAT, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0001);
        // Unmask while the fabric stalls: message held, pending held
        stall <= 1'b1;
        bus(CTRL, 1'b1, 32'h0000_0000);
        repeat (10) @(posedge mclk);
        check32({31'h0, msgValid[0]}, 32'h1);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h4000_0000);
        stall <= 1'b0;
        repeat (10) @(posedge mclk);
        check32({24'h0, msgCount}, 32'h1);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        check32(lastMsg.data, 32'hABCD_1234);
        check32({lastMsg.dwordAddr, 2'b00}, 32'h1234_5678);
        check32(lastMsg.upperAddr, 32'hFEDC_BA98);
        // Completion with status still set is no new condition
        pulse();
        repeat (10) @(posedge mclk);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        check32({24'h0, msgCount}, 32'h1);
        // Servicing the status drops pending without a message
        bus(CTRL, 1'b1, 32'h8000_0000);
        bus(STAT, 1'b1, 32'h0000_0001);
        bus(STAT, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        pulse();
        bus(CTRL, 1'b1, 32'hC000_0000);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'hC000_0000);
        bus(STAT, 1'b1, 32'h0000_0001);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h8000_0000);
        bus(CTRL, 1'b1, 32'h0000_0000);
        repeat (10) @(posedge mclk);
        check32({24'h0, msgCount}, 32'h1);
        // Interrupt line: raised, cleared, masked, unmasked
        check32({31'h0, irq[0]}, 32'h1);
        bus(IRQS, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0007);
        bus(IRQS, 1'b1, 32'h0000_0007);
        bus(IRQM, 1'b1, 32'h0000_0000);
        check32({31'h0, irq[0]}, 32'h0);
        bus(STAT, 1'b1, 32'h0000_0001);
        // Completion without the interrupt flag is no condition
        waitDone <= 1'b1;
        waitFlag <= 1'b0;
        @(posedge mclk);
        waitDone <= 1'b0;
        waitFlag <= 1'b1;
        bus(STAT, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        bus(CTRL, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        pulse();
        repeat (10) @(posedge mclk);
        check32({24'h0, msgCount}, 32'h2);
        check32({31'h0, irq[0]}, 32'h0);
        bus(IRQM, 1'b1, 32'h0000_0007);
        check32({31'h0, irq[0]}, 32'h1);
        bus(IRQS, 1'b1, 32'h0000_0007);
        check32({31'h0, irq[0]}, 32'h0);
        // Unmapped place acks and reads zero
        bus(12'h0FC, 1'b1, 32'hFFFF_FFFF);
        bus(12'h0FC, 1'b0, 32'h0);
        check32(rdv[0], 32'h0000_0000);
        tally_and_finish();
    end
endmodule : iei_event_irq_bench
